//--- common/cfa_pkg.sv
package cfa_pkg;
	// system clock and bus rates
	localparam int CLK_HZ     = 50_000_000;
	localparam int RATE_1M    = 1_000_000;
	localparam int RATE_800K  = 800_000;
	localparam int RATE_500K  = 500_000;
	localparam int RATE_250K  = 250_000;
	localparam int RATE_125K  = 125_000;
	localparam int RATE_50K   = 50_000;
	localparam int RATE_20K   = 20_000;
	localparam int RATE_10K   = 10_000;
	localparam int DIV_W      = 13;
	localparam int BAUD_SEL_W = 3;

	// baud select codes
	localparam logic [BAUD_SEL_W-1:0] BAUD_1M   = 3'h0;
	localparam logic [BAUD_SEL_W-1:0] BAUD_800K = 3'h1;
	localparam logic [BAUD_SEL_W-1:0] BAUD_500K = 3'h2;
	localparam logic [BAUD_SEL_W-1:0] BAUD_250K = 3'h3;
	localparam logic [BAUD_SEL_W-1:0] BAUD_125K = 3'h4;
	localparam logic [BAUD_SEL_W-1:0] BAUD_50K  = 3'h5;
	localparam logic [BAUD_SEL_W-1:0] BAUD_20K  = 3'h6;

	// frame field widths
	localparam int ID_BITS        = 11;
	localparam int ARB_BITS       = ID_BITS + 1;
	localparam int CTRL_BITS      = 6;
	localparam int CTRL_FLAG_BITS = 2;
	localparam int DLC_BITS       = 4;
	localparam int MAX_BYTES      = 8;
	localparam int DATA_MAX_BITS  = 64;
	localparam int CRC_FIELD_BITS = 15;
	localparam int CRC_BITS       = CRC_FIELD_BITS - 1;
	localparam int ACK_BITS       = 2;
	localparam int EOF_IFS_BITS   = 10;
	localparam int NODE_ID_BITS   = 7;
	localparam int SOF_BITS       = 1;
	localparam int FRAME_MIN_BITS = SOF_BITS + ARB_BITS + CTRL_BITS + CRC_FIELD_BITS
		+ ACK_BITS + EOF_IFS_BITS;
	localparam int FRAME_MAX_BITS = FRAME_MIN_BITS + DATA_MAX_BITS;
	localparam int TX_SH_BITS     = ARB_BITS + CTRL_BITS + DATA_MAX_BITS;
	localparam int CNT_W          = 7;

	localparam logic [CRC_BITS-1:0] CRC_POLY = 14'h0599;
	localparam logic [CRC_BITS-1:0] CRC_INIT = 14'h0000;

	localparam logic DOMINANT  = 1'b0;
	localparam logic RECESSIVE = 1'b1;

	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_ARB  = 7'h02,
		ST_CTRL = 7'h04,
		ST_DATA = 7'h08,
		ST_CRC  = 7'h10,
		ST_ACK  = 7'h20,
		ST_EOF  = 7'h40
	} cfa_state_t;

	// clocks per bit; 800k truncates to a whole count
	function automatic logic [DIV_W-1:0] cfa_baud_div(input logic [BAUD_SEL_W-1:0] sel);
		logic [DIV_W-1:0] d;
		d = DIV_W'(CLK_HZ / RATE_10K);
		if (sel == BAUD_1M)
			d = DIV_W'(CLK_HZ / RATE_1M);
		else if (sel == BAUD_800K)
			d = DIV_W'(CLK_HZ / RATE_800K);
		else if (sel == BAUD_500K)
			d = DIV_W'(CLK_HZ / RATE_500K);
		else if (sel == BAUD_250K)
			d = DIV_W'(CLK_HZ / RATE_250K);
		else if (sel == BAUD_125K)
			d = DIV_W'(CLK_HZ / RATE_125K);
		else if (sel == BAUD_50K)
			d = DIV_W'(CLK_HZ / RATE_50K);
		else if (sel == BAUD_20K)
			d = DIV_W'(CLK_HZ / RATE_20K);
		return d;
	endfunction
endpackage

//--- rtl/cfa_bit_tick.sv
`timescale 1ns/1ns
module cfa_bit_tick
	import cfa_pkg::*;
(
	// clock and reset
	input  wire logic                            ref_clk,
	input  wire logic                            rst_n,
	// rate select, held stable after reset
	input  wire logic [cfa_pkg::BAUD_SEL_W-1:0]  baud_sel,
	// one pulse per bit time
	output logic                                 bit_tick
);
	logic [DIV_W-1:0] cnt_reg;
	logic [DIV_W-1:0] div_w;
	logic             wrap_w;

	assign div_w  = cfa_baud_div(baud_sel);
	assign wrap_w = (cnt_reg == div_w - DIV_W'(1));

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cnt_reg  <= '0;
			bit_tick <= 1'b0;
		end else begin
			cnt_reg  <= wrap_w ? '0 : cnt_reg + DIV_W'(1);
			bit_tick <= wrap_w;
		end
	end
endmodule

//--- rtl/cfa_node.sv
`timescale 1ns/1ns
module cfa_node
	import cfa_pkg::*;
(
	// clock and reset
	input  wire logic                               ref_clk,
	input  wire logic                               rst_n,
	// strap, caught while reset is held
	input  wire logic [cfa_pkg::BAUD_SEL_W-1:0]     baud_sel,
	// acceptance setup
	input  wire logic [cfa_pkg::NODE_ID_BITS-1:0]   node_id,
	input  wire logic [cfa_pkg::ID_BITS-1:0]        acc_id,
	input  wire logic [cfa_pkg::ID_BITS-1:0]        acc_mask,
	// bus pins, 0 dominant
	input  wire logic                               can_rx,
	output logic                                    can_tx,
	// transmit request
	input  wire logic                               tx_req,
	input  wire logic [cfa_pkg::ID_BITS-1:0]        tx_id,
	input  wire logic                               tx_rtr,
	input  wire logic [cfa_pkg::DLC_BITS-1:0]       tx_dlc,
	input  wire logic [cfa_pkg::DATA_MAX_BITS-1:0]  tx_data,
	output logic                                    tx_ready,
	output logic                                    tx_done,
	output logic                                    tx_lost,
	// received frame
	output logic                                    rx_valid,
	output logic [cfa_pkg::ID_BITS-1:0]             rx_id,
	output logic                                    rx_rtr,
	output logic [cfa_pkg::DLC_BITS-1:0]            rx_dlc,
	output logic [cfa_pkg::DATA_MAX_BITS-1:0]       rx_data,
	// status
	output logic                                    bus_idle
);
	logic [BAUD_SEL_W-1:0]    baud_reg;
	cfa_state_t               state_reg, state_next;
	logic [CNT_W-1:0]         cnt_reg, cnt_next;
	logic [CNT_W-1:0]         data_bits_reg;
	logic [CNT_W-1:0]         idle_cnt_reg;
	logic                     pending_reg;
	logic [TX_SH_BITS-1:0]    frame_reg;
	logic [TX_SH_BITS-1:0]    tx_sh_reg, tx_sh_next;
	logic                     tx_act_reg, tx_act_next;
	logic                     acked_reg;
	logic [CRC_BITS-1:0]      crc_reg, crc_next;
	logic                     crc_bad_reg, crc_bad_next;
	logic [ARB_BITS-1:0]      rx_arb_reg;
	logic [CTRL_BITS-1:0]     rx_ctrl_reg;
	logic [DATA_MAX_BITS-1:0] rx_sh_reg;
	logic                     bit_tick;

	// samples and field decode
	logic                     samp;
	logic                     bus_free;
	logic                     start_tx;
	logic                     field_last;
	logic                     lose_arb;
	logic [DLC_BITS-1:0]      dlc_now;
	logic [CNT_W-1:0]         data_bits_w;
	logic                     crc_bit_w;
	logic                     tx_bit_w;
	logic                     ack_drive;
	logic                     frame_end;
	logic                     ack_end;

	function automatic logic crc_step(input logic [CRC_BITS-1:0] c, input logic b);
		crc_step = b ^ c[CRC_BITS-1];
	endfunction

	function automatic logic [CRC_BITS-1:0] crc_upd(input logic [CRC_BITS-1:0] c,
		input logic b);
		crc_upd = {c[CRC_BITS-2:0], 1'b0} ^ (crc_step(c, b) ? CRC_POLY : '0);
	endfunction

	function automatic logic id_accept(input logic [ID_BITS-1:0] id);
		id_accept = (((id ^ acc_id) & acc_mask) == '0) ||
			(id[NODE_ID_BITS-1:0] == node_id);
	endfunction

	cfa_bit_tick u_tick (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.baud_sel (baud_reg),
		.bit_tick (bit_tick)
	);

	assign samp      = can_rx;
	assign bus_free  = (idle_cnt_reg == CNT_W'(EOF_IFS_BITS));
	assign start_tx  = bit_tick && (state_reg == ST_IDLE) && bus_free && pending_reg &&
		!tx_act_reg && (samp == RECESSIVE);
	// recessive driven, dominant seen: lost the contest
	assign lose_arb  = bit_tick && (state_reg == ST_ARB) && tx_act_reg &&
		(can_tx == RECESSIVE) && (samp == DOMINANT);
	assign dlc_now   = {rx_ctrl_reg[DLC_BITS-2:0], samp};
	// length codes above eight still carry eight bytes; remote frames carry none
	assign data_bits_w = rx_arb_reg[0] ? '0 :
		(dlc_now > DLC_BITS'(MAX_BYTES)) ? CNT_W'(DATA_MAX_BITS) :
		CNT_W'({dlc_now, 3'h0});
	assign field_last = (state_reg == ST_ARB  && cnt_reg == CNT_W'(ARB_BITS - 1)) ||
		(state_reg == ST_CTRL && cnt_reg == CNT_W'(CTRL_BITS - 1)) ||
		(state_reg == ST_DATA && cnt_reg == data_bits_reg - CNT_W'(1)) ||
		(state_reg == ST_CRC  && cnt_reg == CNT_W'(CRC_FIELD_BITS - 1)) ||
		(state_reg == ST_ACK  && cnt_reg == CNT_W'(ACK_BITS - 1)) ||
		(state_reg == ST_EOF  && cnt_reg == CNT_W'(EOF_IFS_BITS - 1));
	assign frame_end = bit_tick && field_last && (state_reg == ST_EOF);
	assign ack_end   = bit_tick && field_last && (state_reg == ST_ACK);

	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		if (bit_tick && state_reg == ST_IDLE && samp == DOMINANT) begin
			state_next = ST_ARB;
			cnt_next   = '0;
		end else if (bit_tick && state_reg != ST_IDLE) begin
			cnt_next = field_last ? '0 : cnt_reg + CNT_W'(1);
			if (field_last) begin
				case (state_reg)
					ST_ARB:  state_next = ST_CTRL;
					ST_CTRL: state_next = (data_bits_w == '0) ? ST_CRC : ST_DATA;
					ST_DATA: state_next = ST_CRC;
					ST_CRC:  state_next = ST_ACK;
					ST_ACK:  state_next = ST_EOF;
					default: state_next = ST_IDLE;
				endcase
			end
		end
	end

	// checksum covers start bit through payload, taken from sampled bits
	assign crc_next = !bit_tick ? crc_reg :
		(state_reg == ST_IDLE) ? ((samp == DOMINANT) ? crc_upd(CRC_INIT, samp) : CRC_INIT) :
		(state_reg == ST_ARB || state_reg == ST_CTRL || state_reg == ST_DATA) ?
			crc_upd(crc_reg, samp) :
		(state_reg == ST_CRC) ? {crc_reg[CRC_BITS-2:0], 1'b0} : crc_reg;
	assign crc_bit_w = (state_reg == ST_CRC) && (cnt_reg < CNT_W'(CRC_BITS)) &&
		(samp != crc_reg[CRC_BITS-1]);
	assign crc_bad_next = (bit_tick && state_reg == ST_IDLE) ? 1'b0 :
		crc_bad_reg || (bit_tick && (crc_bit_w ||
		(state_reg == ST_CRC && field_last && samp != RECESSIVE)));

	// shifter reloads from the held frame so a retry resends it intact
	assign tx_sh_next = start_tx ? frame_reg :
		(bit_tick && (state_reg == ST_ARB || state_reg == ST_CTRL || state_reg == ST_DATA)) ?
		{tx_sh_reg[TX_SH_BITS-2:0], RECESSIVE} : tx_sh_reg;
	assign tx_act_next = start_tx ? 1'b1 : (lose_arb || frame_end) ? 1'b0 : tx_act_reg;

	// a correct receiver answers in the ack slot; the sender leaves it recessive
	assign ack_drive = !tx_act_next && !crc_bad_next && state_next == ST_ACK &&
		cnt_next == '0;
	assign tx_bit_w = start_tx ? DOMINANT :
		(tx_act_next && (state_next == ST_ARB || state_next == ST_CTRL ||
		state_next == ST_DATA)) ? tx_sh_next[TX_SH_BITS-1] :
		(tx_act_next && state_next == ST_CRC && cnt_next < CNT_W'(CRC_BITS)) ?
			crc_next[CRC_BITS-1] :
		ack_drive ? DOMINANT : RECESSIVE;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			baud_reg <= baud_sel;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_reg    <= ST_IDLE;
			cnt_reg      <= '0;
			idle_cnt_reg <= '0;
			tx_act_reg   <= 1'b0;
			tx_sh_reg    <= '0;
			crc_reg      <= CRC_INIT;
			crc_bad_reg  <= 1'b0;
			can_tx       <= RECESSIVE;
		end else begin
			state_reg   <= state_next;
			cnt_reg     <= cnt_next;
			tx_act_reg  <= tx_act_next;
			tx_sh_reg   <= tx_sh_next;
			crc_reg     <= crc_next;
			crc_bad_reg <= crc_bad_next;
			if (bit_tick)
				can_tx <= tx_bit_w;
			// ten recessive samples mark the bus free; the end field counts as such
			if (frame_end)
				idle_cnt_reg <= CNT_W'(EOF_IFS_BITS);
			else if (bit_tick && state_reg == ST_IDLE)
				idle_cnt_reg <= (samp == DOMINANT) ? '0 :
					bus_free ? idle_cnt_reg : idle_cnt_reg + CNT_W'(1);
			else if (bit_tick)
				idle_cnt_reg <= '0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pending_reg <= 1'b0;
			frame_reg   <= '0;
			acked_reg   <= 1'b0;
			tx_ready    <= 1'b0;
			tx_done     <= 1'b0;
			tx_lost     <= 1'b0;
		end else begin
			tx_done  <= frame_end && tx_act_reg && acked_reg;
			tx_lost  <= lose_arb;
			tx_ready <= !(pending_reg || tx_req) || (frame_end && tx_act_reg && acked_reg);
			if (frame_end && tx_act_reg && acked_reg)
				pending_reg <= 1'b0;
			else if (tx_req && !pending_reg) begin
				pending_reg <= 1'b1;
				frame_reg   <= {tx_id, tx_rtr, DOMINANT, DOMINANT, tx_dlc, tx_data};
			end
			if (bit_tick && state_reg == ST_ACK && cnt_reg == '0)
				acked_reg <= (samp == DOMINANT);
			else if (start_tx)
				acked_reg <= 1'b0;
		end
	end

	// receive side shifts every sampled arbitration, control and data bit, sender included
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rx_arb_reg    <= '0;
			rx_ctrl_reg   <= '0;
			rx_sh_reg     <= '0;
			data_bits_reg <= '0;
			rx_valid      <= 1'b0;
			rx_id         <= '0;
			rx_rtr        <= 1'b0;
			rx_dlc        <= '0;
			rx_data       <= '0;
			bus_idle      <= 1'b0;
		end else begin
			bus_idle <= (state_next == ST_IDLE) && bus_free;
			rx_valid <= 1'b0;
			if (bit_tick && state_reg == ST_ARB)
				rx_arb_reg <= {rx_arb_reg[ARB_BITS-2:0], samp};
			if (bit_tick && state_reg == ST_CTRL)
				rx_ctrl_reg <= {rx_ctrl_reg[CTRL_BITS-2:0], samp};
			if (bit_tick && state_reg == ST_CTRL && field_last)
				data_bits_reg <= data_bits_w;
			if (bit_tick && state_reg == ST_DATA)
				rx_sh_reg <= {rx_sh_reg[DATA_MAX_BITS-2:0], samp};
			else if (bit_tick && state_reg == ST_IDLE)
				rx_sh_reg <= '0;
			// own frames and filtered-out identifiers are not delivered
			if (ack_end && !tx_act_reg && !crc_bad_reg &&
				id_accept(rx_arb_reg[ARB_BITS-1:1])) begin
				rx_valid <= 1'b1;
				rx_id    <= rx_arb_reg[ARB_BITS-1:1];
				rx_rtr   <= rx_arb_reg[0];
				rx_dlc   <= rx_ctrl_reg[DLC_BITS-1:0];
				rx_data  <= rx_sh_reg << (CNT_W'(DATA_MAX_BITS) - data_bits_reg);
			end
		end
	end
endmodule

//--- tb/cfa_node_props.sv
`timescale 1ns/1ns
module cfa_node_props (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// watched pins
	input wire logic can_rx,
	input wire logic can_tx,
	input wire logic tx_req,
	input wire logic tx_ready,
	input wire logic tx_done,
	input wire logic tx_lost,
	input wire logic rx_valid
);
	// clocks of recessive bus, clocks since own dominant
	int quiet;
	int since_low;
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			quiet <= 0;
			since_low <= 0;
		end else begin
			quiet <= can_rx ? quiet + 1 : 0;
			since_low <= can_tx ? since_low + 1 : 0;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	a_take_request: assert property (tx_req && tx_ready |=> !tx_ready)
		else $error("request taken but ready stayed high");
	a_done_frees: assert property (tx_done |-> $past(tx_ready) == 1'b0 ##[0:1] tx_ready)
		else $error("done without freeing the request slot");
	a_done_pulse: assert property (tx_done |=> !tx_done)
		else $error("done longer than one cycle");
	a_lost_quiet: assert property (tx_lost |-> can_tx [*8])
		else $error("still driving dominant after losing");
	a_lost_pending: assert property (tx_lost |-> !tx_ready && !tx_done)
		else $error("lost frame not kept pending");
	a_bit_hold: assert property ($changed(can_tx) |=> $stable(can_tx) [*8])
		else $error("drive level changed inside a bit");
	// fastest rate is 50 clocks a bit: ack delimiter plus ten end bits
	a_end_gap: assert property (tx_done |-> quiet >= 540)
		else $error("frame ended before the end field ran out");
	a_ack_given: assert property (rx_valid |-> since_low >= 40 && since_low <= 60)
		else $error("received frame not acknowledged in its slot");
endmodule

bind cfa_node cfa_node_props u_cfa_node_props (.ref_clk(ref_clk), .rst_n(rst_n),
	.can_rx(can_rx), .can_tx(can_tx), .tx_req(tx_req), .tx_ready(tx_ready),
	.tx_done(tx_done), .tx_lost(tx_lost), .rx_valid(rx_valid));

//--- tb/cfa_peer.sv
`timescale 1ns/1ns
module cfa_peer (
	// clock, reset, bit tick
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	input  wire logic         tick,
	// frame to send, left aligned
	input  wire logic         send,
	input  wire logic [109:0] frame,
	input  wire logic [6:0]   len,
	// bus, 0 dominant
	input  wire logic         can_rx,
	output logic              can_tx
);
	int         pos;
	int         rec;
	int         nb;
	int         nx;
	logic       own;
	logic       snd;
	logic       b;
	logic [6:0] hd;
	// blocking temporaries keep the bit bookkeeping in one place
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			pos = -1;
			rec = 0;
			hd = 7'h00;
			own = 1'b0;
			snd = 1'b0;
			can_tx <= 1'b1;
		end else begin
			if (tick) begin
				b = can_rx;
				rec = (pos < 0 && b) ? rec + 1 : 0;
				pos = (pos >= 0) ? pos + 1 : (b ? -1 : 0);
				if (pos >= 0 && pos <= 18)
					hd = {hd[5:0], b};
				nb = hd[6] ? 0 : (hd[3:0] > 8 ? 64 : 8 * hd[3:0]);
				if (own && pos >= 1 && pos <= 12 && frame[109 - pos] && !b)
					own = 1'b0;
				if (pos == 45 + nb) begin
					snd = snd && !own;
					own = 1'b0;
					pos = -1;
					rec = 10;
				end
				if (pos < 0 && snd && rec >= 10)
					own = 1'b1;
				nx = pos + 1;
				if (own)
					can_tx <= (nx < len) ? frame[109 - nx] : 1'b1;
				else
					can_tx <= !(pos >= 0 && nx == 34 + nb);
			end
			// a request counts from the next tick, as the node's pending flag does
			if (send)
				snd = 1'b1;
		end
	end
endmodule

//--- tb/cfa_node_tb_top.sv
`timescale 1ns/1ns
module cfa_node_tb_top;
	import cfa_pkg::*;
	logic         ref_clk = 1'b0;
	logic         rst_n = 1'b0;
	logic [2:0]   baud_sel = 3'h0;
	logic [6:0]   node_id = 7'h7f;
	logic [10:0]  acc_id = 11'h000;
	logic [10:0]  acc_mask = 11'h7ff;
	logic         tx_req = 1'b0;
	logic [10:0]  tx_id = 11'h000;
	logic         tx_rtr = 1'b0;
	logic [3:0]   tx_dlc = 4'h0;
	logic [63:0]  tx_data = 64'h0;
	logic         send = 1'b0;
	logic [109:0] pfr = '1;
	logic [109:0] efr;
	logic [109:0] shf;
	logic [79:0]  erx;
	logic         node_tx, peer_tx, tick, tx_ready, tx_done, tx_lost, rx_valid, rx_rtr, bus_idle;
	logic [10:0]  rx_id;
	logic [3:0]   rx_dlc;
	logic [63:0]  rx_data;
	logic         cap = 1'b0;
	logic [9:0]   hist = '1;
	int           plen = 46, elen, nbits, cyc = 0, err_count = 0, compares = 0;
	int           seed = 32'hfd7f;
	int           tdiv = 0;
	int           rates [8] = '{RATE_1M, RATE_800K, RATE_500K, RATE_250K, RATE_125K,
		RATE_50K, RATE_20K, RATE_10K};
	wire          can_rx = node_tx & peer_tx;
	wire  [5:0]   ev = {bus_idle, tx_ready, rx_valid, tx_lost, tx_done, u_cfa_node.bit_tick};

	always #10 ref_clk = ~ref_clk;
	always @(posedge ref_clk) cyc++;
	// partner's own bit clock, restarted by reset like the node's divider
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			tdiv <= 0;
			tick <= 1'b0;
		end else begin
			tick <= (tdiv == CLK_HZ / rates[baud_sel] - 1);
			tdiv <= (tdiv == CLK_HZ / rates[baud_sel] - 1) ? 0 : tdiv + 1;
		end
	end
	cfa_peer u_cfa_peer (.ref_clk(ref_clk), .rst_n(rst_n), .tick(tick), .send(send),
		.frame(pfr), .len(plen[6:0]), .can_rx(can_rx), .can_tx(peer_tx));
	cfa_node u_cfa_node (.ref_clk(ref_clk), .rst_n(rst_n), .baud_sel(baud_sel),
		.node_id(node_id), .acc_id(acc_id), .acc_mask(acc_mask), .can_rx(can_rx),
		.can_tx(node_tx), .tx_req(tx_req), .tx_id(tx_id), .tx_rtr(tx_rtr), .tx_dlc(tx_dlc),
		.tx_data(tx_data), .tx_ready(tx_ready), .tx_done(tx_done), .tx_lost(tx_lost),
		.rx_valid(rx_valid), .rx_id(rx_id), .rx_rtr(rx_rtr), .rx_dlc(rx_dlc),
		.rx_data(rx_data), .bus_idle(bus_idle));

	function automatic logic [109:0] mk(input logic [10:0] id, input logic r,
		input logic [3:0] d, input logic [63:0] dat, output int n);
		logic [82:0]  s;
		logic [13:0]  c;
		logic [109:0] f;
		s = {1'b0, id, r, 2'b00, d, dat};
		c = CRC_INIT;
		f = '1;
		n = 19 + (r ? 0 : (d > 8 ? 64 : 8 * d));
		for (int i = 0; i < n; i++) begin
			f[109 - i] = s[82 - i];
			c = {c[12:0], 1'b0} ^ ((s[82 - i] ^ c[13]) ? CRC_POLY : 14'h0);
		end
		for (int i = 0; i < 14; i++)
			f[109 - n - i] = c[13 - i];
		n = n + 27;
		return f;
	endfunction

	task automatic chk(input string nm, input logic [109:0] e, input logic [109:0] g);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wt(input int w, input int lim, output bit h);
		h = 1'b0;
		repeat (lim) begin
			@(negedge ref_clk);
			if (ev[w] === 1'b1) begin
				h = 1'b1;
				break;
			end
		end
	endtask

	task automatic rst(input logic [2:0] b);
		@(posedge ref_clk);
		baud_sel <= b;
		rst_n <= 1'b0;
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
	endtask

	// node and peer requests launched on the same edge so both start on one bit
	task automatic req(input bit n, input bit p, input logic [10:0] id,
		input logic [10:0] pid, input logic r, input logic [3:0] d);
		logic [63:0] dat;
		dat = {$random(seed), $random(seed)};
		@(posedge ref_clk);
		tx_id <= id;
		tx_rtr <= r;
		tx_dlc <= d;
		tx_data <= dat;
		tx_req <= n;
		send <= p;
		pfr <= mk(pid, r, d, ~dat, plen);
		erx = {pid, r, d, ~dat & (~64'h0 << (110 - plen))};
		efr = mk(id, r, d, dat, elen);
		@(posedge ref_clk);
		tx_req <= 1'b0;
		send <= 1'b0;
	endtask

	task automatic finish_test;
		$display("compares %0d errors %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// own bits as sampled on each tick, from a start after ten recessive bits
	always @(posedge ref_clk) begin
		if (tick) begin
			// bus_idle keeps an ack bit during reception from passing for a start bit
			if (!cap && !node_tx && hist == 10'h3ff && !tx_ready && bus_idle) begin
				cap = 1'b1;
				nbits = 0;
				shf = '0;
			end
			if (cap) begin
				shf = {shf[108:0], node_tx};
				nbits++;
			end
			hist = {hist[8:0], can_rx};
		end
		if (tx_lost)
			cap = 1'b0;
		if (tx_done) begin
			chk("tx frame", efr >> (110 - elen), shf);
			chk("tx length", elen, nbits);
			cap = 1'b0;
		end
	end

	initial begin
		bit          h;
		int          t0;
		logic [10:0] id;
		logic [3:0]  d;
		for (int k = 0; k < 8; k++) begin
			rst(k[2:0]);
			wt(0, 6000, h);
			t0 = cyc;
			wt(0, 6000, h);
			chk("bit period", CLK_HZ / rates[k], cyc - t0);
			chk("tick align", 1, tick);
		end
		$display("test rates done");
		rst(BAUD_1M);
		wt(5, 1000, h);
		chk("bus idle", 1, h);
		for (int k = 0; k < 5; k++) begin
			wt(4, 100, h);
			id = $random(seed);
			d = k == 0 ? 4'h0 : k == 1 ? 4'h8 : k == 2 ? 4'hf : 4'({$random(seed)} % 9);
			req(1, 0, id, id, k == 3, d);
			wt(1, 7000, h);
			chk("tx done", 1, h);
		end
		$display("test transmit done");
		for (int k = 0; k < 3; k++) begin
			// the peer's frame port must not change while it is still sending
			wt(5, 7000, h);
			@(posedge ref_clk);
			id = $random(seed) & 11'h7fe;
			acc_id <= k == 0 ? id : id ^ 11'h001;
			node_id <= k == 2 ? id[6:0] : 7'h7f;
			req(0, 1, id, id, k == 1, 4'(k * 4));
			wt(3, 6000, h);
			chk("rx accept", k != 1, h);
			if (h)
				chk("rx fields", erx, {rx_id, rx_rtr, rx_dlc, rx_data});
		end
		$display("test receive done");
		for (int k = 0; k < 2; k++) begin
			wt(5, 7000, h);
			@(posedge ref_clk);
			node_id <= k ? 7'h20 : 7'h40;
			req(1, 1, k ? 11'h0c0 : 11'h0a0, k ? 11'h0a0 : 11'h0c0, 1'b0, 4'h2);
			if (k) begin
				wt(2, 1000, h);
				chk("tx lost", 1, h);
			end
			wt(k ? 3 : 1, 7000, h);
			chk("first end", 1, h);
			wt(k ? 1 : 3, 7000, h);
			chk("second end", 1, h);
			chk("rx fields", erx, {rx_id, rx_rtr, rx_dlc, rx_data});
		end
		$display("test arbitration done");
		finish_test;
	end

	initial begin
		repeat (90000) @(posedge ref_clk);
		err_count++;
		finish_test;
	end
endmodule
